// >>> core/sebl_defs.svh
// Constants of the coefficient boot loader: offsets, fields, resets, timing.
// Assumes a 200 MHz system clock; included by bare name from core/.
`ifndef SEBL_DEFS_SVH
`define SEBL_DEFS_SVH

// Register offsets on the control port
`define SEBL_OFS_GAIN      8'h54
`define SEBL_OFS_SCLK      8'h55
`define SEBL_OFS_CTRL      8'h56
`define SEBL_OFS_OPCODE    8'h57
`define SEBL_OFS_ADDR_HI   8'h58
`define SEBL_OFS_ADDR_MID  8'h59
`define SEBL_OFS_ADDR_LO   8'h5A
`define SEBL_OFS_STATUS    8'h5B
`define SEBL_OFS_BIQUAD    8'h5C
`define SEBL_OFS_SUPPLY    8'h5E

// Field positions in boot_loader_ctrl
`define SEBL_CTL_SRC       0
`define SEBL_CTL_LSB       1
`define SEBL_CTL_EDGE      2
`define SEBL_CTL_WIDE      5
// Field positions in boot_load_status
`define SEBL_STS_DONE      0
`define SEBL_STS_CRC       1

// Reset values
`define SEBL_RST_ZERO      8'h00
`define SEBL_RST_OPCODE    8'h03

// Timing: clock period and serial clock half periods, in ns
`define SEBL_CLK_NS        5
`define SEBL_HALF_NS_0     400
`define SEBL_HALF_NS_1     200
`define SEBL_HALF_NS_2     100
`define SEBL_HALF_NS_3     50
`define SEBL_HALF_CYC(ns)  ((ns) / `SEBL_CLK_NS)

// Coefficient image and check, gain step and FIFO depth
`define SEBL_IMAGE_BYTES   16'd64
`define SEBL_CRC_POLY      8'h07
`define SEBL_GAIN_TENTHS   8'd5
`define SEBL_FIFO_DEPTH    32

`endif

// >>> core/sebl_pkg.sv
// Types shared by the coefficient boot loader.
// Assumes nothing beyond a SystemVerilog compiler.
package sebl_pkg;

  // Serial master pins, all driven by the loader
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sebl_spi_t;

  // One access on the register port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sebl_reg_req_t;

  // Load sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_BYTE = 6'h04,
    ST_POST = 6'h08,
    ST_WAIT = 6'h10,
    ST_DONE = 6'h20
  } sebl_state_t;

endpackage

// >>> core/sebl_loader.sv
// Coefficient boot loader: register file, serial master, image FIFO.
// Assumes register port and host stream on the system clock;
// the serial data input comes from an external EEPROM.
`include "sebl_defs.svh"

// Coefficient buffer between loader or host and the DSP.
// Depth must be a power of two; flags are registered.
module sebl_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];    // Storage words
  logic [AW-1:0] wr_ptr_r;  // Next slot to write
  logic [AW-1:0] rd_ptr_r;  // Next slot to read
  logic [AW:0]   cnt_r;     // Words held
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem[rd_ptr_r];

  // Storage writes need no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, count and flags; flags look ahead so they never lag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      cnt_r     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r  <= wr_ptr_r + AW'(push);
      rd_ptr_r  <= rd_ptr_r + AW'(pop);
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != (AW + 1)'(D);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule

module sebl_loader
  import sebl_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Register port
  input  wire sebl_reg_req_t reg_req,
  output logic [7:0]         reg_rdata,
  // Supply voltage sample from the converter
  input  wire logic [7:0]    supply_sample,
  // Serial master pins
  output sebl_spi_t          spi,
  input  wire logic          spi_miso,
  // Host coefficient stream
  input  wire logic          host_coef_valid,
  input  wire logic [7:0]    host_coef_data,
  output logic               host_coef_ready,
  // Coefficient stream toward the DSP
  output logic               coef_valid,
  input  wire logic          coef_ready,
  output logic [7:0]         coef_data,
  // Control levels toward the analog and DSP sides
  output logic [4:0]         analog_gain_code,
  output logic [7:0]         gain_atten_tenths,
  output logic               biquad_first_coef_marker,
  output logic               load_busy
);

  // Software registers
  logic [7:0] gain_r;      // analog_gain_ctrl
  logic [7:0] sclk_r;      // serial_clock_select
  logic [7:0] ctrl_r;      // boot_loader_ctrl
  logic [7:0] opcode_r;    // boot_read_opcode
  logic [7:0] addr_hi_r;   // boot_start_addr_high
  logic [7:0] addr_mid_r;  // boot_start_addr_middle
  logic [7:0] addr_lo_r;   // boot_start_addr_low
  logic [7:0] biquad_r;    // biquad_write_ctrl
  logic [7:0] supply_r;    // supply_voltage_reading
  logic       done_r;      // Load finished flag
  logic       crc_err_r;   // Load check failed flag

  // Sequencer state
  sebl_state_t state_r;
  logic [7:0]  div_r;      // Half period divider
  logic [3:0]  tick_r;     // Half periods within a byte
  logic [15:0] idx_r;      // Byte index in the transaction
  logic [7:0]  tx_r;       // Outgoing shift register
  logic [7:0]  rx_r;       // Incoming shift register
  logic [7:0]  crc_r;      // Running check over the image
  logic        push_r;     // Received byte offered to the FIFO
  logic        start;      // Software asked for a load
  logic        tick;       // Half period elapsed
  logic        rising;     // This tick raises the serial clock
  logic        launch;     // This tick moves the data line
  logic [2:0]  hdr_len;    // Opcode plus address bytes
  logic [15:0] total_len;  // Whole transaction length
  logic        is_data;    // Current byte belongs to the image

  // Input synchroniser for the EEPROM data line
  logic miso_s1_r;
  logic miso_s2_r;

  // FIFO wiring
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] fifo_in_data;

  // Half period in system cycles for a rate code
  function automatic logic [7:0] half_cyc(input logic [1:0] code);
    unique case (code)
      2'h0: half_cyc = 8'(`SEBL_HALF_CYC(`SEBL_HALF_NS_0));
      2'h1: half_cyc = 8'(`SEBL_HALF_CYC(`SEBL_HALF_NS_1));
      2'h2: half_cyc = 8'(`SEBL_HALF_CYC(`SEBL_HALF_NS_2));
      2'h3: half_cyc = 8'(`SEBL_HALF_CYC(`SEBL_HALF_NS_3));
    endcase
  endfunction

  // Bit that goes out next, by bit order
  function automatic logic cur_bit(input logic [7:0] v, input logic lsb);
    cur_bit = lsb ? v[0] : v[7];
  endfunction

  // Advance the outgoing register by one bit
  function automatic logic [7:0] shift_tx(input logic [7:0] v, input logic lsb);
    shift_tx = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  // One byte step of the image check
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ `SEBL_CRC_POLY) : (x << 1);
    end
    crc8 = x;
  endfunction

  // Header byte by position; the narrow form skips the high byte
  function automatic logic [7:0] hdr_byte(input logic [15:0] i, input logic wide);
    logic [2:0] p;
    p = (i > 16'd3) ? 3'd4 : (wide || i == 16'd0) ? i[2:0] : 3'(i[2:0] + 3'd1);
    unique case (p)
      3'd0:    hdr_byte = opcode_r;
      3'd1:    hdr_byte = addr_hi_r;
      3'd2:    hdr_byte = addr_mid_r;
      3'd3:    hdr_byte = addr_lo_r;
      default: hdr_byte = 8'h00;       // Dummy bytes while reading
    endcase
  endfunction

  // Transaction shape
  assign hdr_len   = ctrl_r[`SEBL_CTL_WIDE] ? 3'd4 : 3'd3;
  assign total_len = {13'd0, hdr_len} + `SEBL_IMAGE_BYTES;
  assign is_data   = idx_r >= {13'd0, hdr_len};
  assign start     = reg_req.wr && reg_req.addr == `SEBL_OFS_CTRL
                     && reg_req.wdata[`SEBL_CTL_SRC] && !ctrl_r[`SEBL_CTL_SRC];
  assign tick      = div_r == half_cyc(sclk_r[1:0]) - 8'd1;
  assign rising    = !spi.sck;
  assign launch    = rising ^ ctrl_r[`SEBL_CTL_EDGE];

  // Two flops before anything reads the data line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= spi_miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // Software register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_r     <= `SEBL_RST_ZERO;
      sclk_r     <= `SEBL_RST_ZERO;
      ctrl_r     <= `SEBL_RST_ZERO;
      opcode_r   <= `SEBL_RST_OPCODE;
      addr_hi_r  <= `SEBL_RST_ZERO;
      addr_mid_r <= `SEBL_RST_ZERO;
      addr_lo_r  <= `SEBL_RST_ZERO;
      biquad_r   <= `SEBL_RST_ZERO;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        `SEBL_OFS_GAIN:     gain_r     <= reg_req.wdata;
        `SEBL_OFS_SCLK:     sclk_r     <= reg_req.wdata;
        `SEBL_OFS_CTRL:     ctrl_r     <= reg_req.wdata;
        `SEBL_OFS_OPCODE:   opcode_r   <= reg_req.wdata;
        `SEBL_OFS_ADDR_HI:  addr_hi_r  <= reg_req.wdata;
        `SEBL_OFS_ADDR_MID: addr_mid_r <= reg_req.wdata;
        `SEBL_OFS_ADDR_LO:  addr_lo_r  <= reg_req.wdata;
        `SEBL_OFS_BIQUAD:   biquad_r   <= reg_req.wdata;
        default:            ;  // Read-only and unmapped writes are dropped
      endcase
    end
  end

  // Supply reading is sampled every cycle; it is same-domain logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supply_r <= `SEBL_RST_ZERO;
    end else begin
      supply_r <= supply_sample;
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `SEBL_OFS_GAIN:     reg_rdata <= gain_r;
        `SEBL_OFS_SCLK:     reg_rdata <= sclk_r;
        `SEBL_OFS_CTRL:     reg_rdata <= ctrl_r;
        `SEBL_OFS_OPCODE:   reg_rdata <= opcode_r;
        `SEBL_OFS_ADDR_HI:  reg_rdata <= addr_hi_r;
        `SEBL_OFS_ADDR_MID: reg_rdata <= addr_mid_r;
        `SEBL_OFS_ADDR_LO:  reg_rdata <= addr_lo_r;
        `SEBL_OFS_STATUS:   reg_rdata <= {6'h00, crc_err_r, done_r};
        `SEBL_OFS_BIQUAD:   reg_rdata <= biquad_r;
        `SEBL_OFS_SUPPLY:   reg_rdata <= supply_r;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // Gain decode: attenuation grows by half a dB per code step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_gain_code  <= 5'h00;
      gain_atten_tenths <= 8'h00;
    end else begin
      analog_gain_code  <= gain_r[4:0];
      gain_atten_tenths <= 8'(gain_r[4:0] * `SEBL_GAIN_TENTHS);
    end
  end

  // Marker level toward the DSP write logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      biquad_first_coef_marker <= 1'b0;
    end else begin
      biquad_first_coef_marker <= biquad_r[0];
    end
  end

  // Load sequencer; a new start is ignored while a load runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (start) state_r <= ST_LEAD;
        ST_LEAD: if (tick) state_r <= ST_BYTE;
        ST_BYTE: if (tick && tick_r == 4'hF) state_r <= ST_POST;
        ST_POST: state_r <= (idx_r == total_len - 16'd1) ? ST_DONE : ST_WAIT;
        // Room is judged only once the pending push has landed, else a byte is lost
        ST_WAIT: if (!is_data || (fifo_in_ready && !push_r)) state_r <= ST_BYTE;
        ST_DONE: if (tick) state_r <= ST_IDLE;
      endcase
    end
  end

  // Half period divider, runs only while the clock is needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
    end else if (state_r inside {ST_LEAD, ST_BYTE, ST_DONE} && !tick) begin
      div_r <= div_r + 8'd1;
    end else begin
      div_r <= 8'h00;
    end
  end

  // Chip select frames the whole transaction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spi.cs_n <= 1'b1;
    end else if (start && state_r == ST_IDLE) begin
      spi.cs_n <= 1'b0;
    end else if (state_r == ST_DONE && tick) begin
      spi.cs_n <= 1'b1;
    end
  end

  // Serial clock: idles low, sixteen toggles per byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spi.sck <= 1'b0;
      tick_r  <= 4'h0;
    end else if (state_r == ST_BYTE && tick) begin
      spi.sck <= !spi.sck;
      tick_r  <= tick_r + 4'h1;
    end
  end

  // Byte index counts opcode, address, then image bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_r <= 16'h0000;
    end else if (state_r == ST_IDLE) begin
      idx_r <= 16'h0000;
    end else if (state_r == ST_POST) begin
      idx_r <= idx_r + 16'd1;
    end
  end

  // Data out: load each byte before its first launch edge.
  // When data moves on falling edges the first bit goes out at load.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_r     <= 8'h00;
      spi.mosi <= 1'b0;
    end else if ((state_r == ST_LEAD && tick)
                 || (state_r == ST_WAIT && (!is_data || (fifo_in_ready && !push_r)))) begin
      if (ctrl_r[`SEBL_CTL_EDGE]) begin
        spi.mosi <= cur_bit(hdr_byte(idx_r, ctrl_r[`SEBL_CTL_WIDE]), ctrl_r[`SEBL_CTL_LSB]);
        tx_r     <= shift_tx(hdr_byte(idx_r, ctrl_r[`SEBL_CTL_WIDE]), ctrl_r[`SEBL_CTL_LSB]);
      end else begin
        tx_r     <= hdr_byte(idx_r, ctrl_r[`SEBL_CTL_WIDE]);
      end
    end else if (state_r == ST_BYTE && tick && launch && tick_r != 4'hF) begin
      spi.mosi <= cur_bit(tx_r, ctrl_r[`SEBL_CTL_LSB]);
      tx_r     <= shift_tx(tx_r, ctrl_r[`SEBL_CTL_LSB]);
    end
  end

  // Data in: capture on the edge opposite the launch edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_r <= 8'h00;
    end else if (state_r == ST_BYTE && tick && !launch) begin
      rx_r <= ctrl_r[`SEBL_CTL_LSB] ? {miso_s2_r, rx_r[7:1]}
                                     : {rx_r[6:0], miso_s2_r};
    end
  end

  // Image bytes go to the FIFO for one cycle; room was checked earlier
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= state_r == ST_POST && is_data;
    end
  end

  // Running check; the image ends in its own check byte, so a clean
  // load leaves zero behind
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc_r <= 8'h00;
    end else if (start && state_r == ST_IDLE) begin
      crc_r <= 8'h00;
    end else if (state_r == ST_POST && is_data) begin
      crc_r <= crc8(crc_r, rx_r);
    end
  end

  // Status flags cleared by a new load; when the frame closes done is set and the check flag shows crc_r != 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_r    <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (start && state_r == ST_IDLE) begin
      done_r    <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (state_r == ST_DONE && tick) begin
      done_r    <= 1'b1;
      crc_err_r <= crc_r != 8'h00;
    end
  end

  // Busy level for the DSP side
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      load_busy <= 1'b0;
    end else begin
      load_busy <= state_r != ST_IDLE || start;
    end
  end

  // Source select: the host stream feeds the FIFO only while clear.
  // The host ready is gated so host words are never taken in EEPROM mode.
  assign fifo_in_valid   = ctrl_r[`SEBL_CTL_SRC] ? push_r : host_coef_valid;
  assign fifo_in_data    = ctrl_r[`SEBL_CTL_SRC] ? rx_r : host_coef_data;
  assign host_coef_ready = fifo_in_ready && !ctrl_r[`SEBL_CTL_SRC];

  // Coefficient buffer toward the DSP
  sebl_fifo #(
    .W (8),
    .D (`SEBL_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (coef_valid),
    .out_ready (coef_ready),
    .out_data  (coef_data)
  );

endmodule

// >>> testbench/sebl_loader_properties.sv
// Checker for the boot loader ports, with shadows of the control writes.
// Assumes it is bound onto sebl_loader and sees its ports only.
`include "sebl_defs.svh"
module sebl_loader_properties
  import sebl_pkg::*;
(
  // Clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // Register port and levels
  input wire sebl_reg_req_t reg_req,
  input wire logic [4:0]    analog_gain_code,
  input wire logic [7:0]    gain_atten_tenths,
  input wire logic          biquad_first_coef_marker,
  input wire logic          load_busy,
  // Serial pins and streams
  input wire sebl_spi_t     spi,
  input wire logic          host_coef_ready,
  input wire logic          coef_valid,
  input wire logic          coef_ready,
  input wire logic [7:0]    coef_data
);
  logic [7:0] sclk_r;   // Shadow of serial_clock_select
  logic [7:0] ctrl_r;   // Shadow of boot_loader_ctrl
  logic [7:0] hi_cnt_r; // Cycles sck has stayed high

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Shadows follow writes; reset clears them as it clears the design
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_r <= 8'h00;
      ctrl_r <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `SEBL_OFS_SCLK) sclk_r <= reg_req.wdata;
      if (reg_req.addr == `SEBL_OFS_CTRL) ctrl_r <= reg_req.wdata;
    end
  end

  // Length of the present high phase of sck
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hi_cnt_r <= 8'h00;
    else hi_cnt_r <= spi.sck ? hi_cnt_r + 8'h01 : 8'h00;
  end

  a_gain_follows: assert property (
    reg_req.wr && reg_req.addr == `SEBL_OFS_GAIN |->
    ##2 analog_gain_code == $past(reg_req.wdata[4:0], 2)) else $error("gain code late");
  a_atten_scale: assert property (
    $stable(analog_gain_code) |-> gain_atten_tenths == analog_gain_code * 8'd5)
    else $error("attenuation wrong");
  a_half_period: assert property (
    $fell(spi.sck) |-> hi_cnt_r == (8'd80 >> sclk_r[1:0])) else $error("sck rate wrong");
  a_sck_idle: assert property (spi.cs_n |-> !spi.sck) else $error("sck not idle");
  a_start_frame: assert property (
    reg_req.wr && reg_req.addr == `SEBL_OFS_CTRL && reg_req.wdata[0] && !ctrl_r[0]
    && !load_busy |-> ##[1:2] (!spi.cs_n && load_busy)) else $error("load did not start");
  a_cs_busy: assert property (!spi.cs_n |-> load_busy) else $error("select without busy");
  a_busy_ends: assert property (
    $rose(spi.cs_n) |-> ##[0:3] !load_busy) else $error("busy stuck");
  a_host_gated: assert property (ctrl_r[0] |-> !host_coef_ready)
    else $error("host path open");
  a_marker_copy: assert property (
    reg_req.wr && reg_req.addr == `SEBL_OFS_BIQUAD |->
    ##2 biquad_first_coef_marker == $past(reg_req.wdata[0], 2)) else $error("marker late");
  a_mosi_settled: assert property (
    !spi.cs_n && (ctrl_r[2] ? $rose(spi.sck) : $fell(spi.sck)) |-> $stable(spi.mosi))
    else $error("data moved at sample edge");
  a_stream_hold: assert property (
    coef_valid && !coef_ready |=> coef_valid && $stable(coef_data)) else $error("word dropped");
endmodule

// >>> testbench/sebl_eeprom_model.sv
// EEPROM stand-in: takes opcode and address, then sends a 64-byte image.
// Assumes the loader drives its pins; format inputs come from the bench.
module sebl_eeprom_model
  import sebl_pkg::*;
(
  // Serial pins
  input  wire sebl_spi_t  spi,
  output logic            miso,
  // Frame format chosen by the bench
  input  wire logic       edge_sel,
  input  wire logic       lsb_first,
  input  wire logic       wide,
  input  wire logic       bad_crc,
  // What arrived on the data line
  output logic [31:0]     rx_hdr,
  output int              rx_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] img [64]; // Image; the last byte zeroes the check
  logic [7:0] rx_byte;  // Byte being assembled
  int         n_tx;     // Next frame bit to send

  initial begin
    miso = 1'b0;
    rx_hdr = 32'h0;
    rx_bits = 0;
    n_tx = 0;
    rx_byte = 8'h00;
  end

  // Counting bytes closed by a CRC-8 byte; bad_crc spoils it on purpose
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 63; i++) begin
      img[i] = 8'h40 + i[7:0];
      c = c ^ img[i];
      for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    img[63] = c ^ {7'h00, bad_crc};
  end

  // Header time and past the image show a changing pattern, not data
  function automatic logic tx_bit(int n);
    int k;
    k = n - (wide ? 32 : 24);
    if (k < 0 || k > 511) return ~miso;
    return lsb_first ? img[k / 8][k % 8] : img[k / 8][7 - k % 8];
  endfunction

  // Frame start; with falling-edge shifting bit 0 is out at once
  always @(negedge spi.cs_n) begin
    rx_bits = 0;
    rx_hdr = 32'h0;
    n_tx = 0;
    if (edge_sel) begin
      miso = tx_bit(0);
      n_tx = 1;
    end
  end

  // Released line shows the inverse of its last bit
  always @(posedge spi.cs_n) miso = ~miso;

  // Sample on one sck edge, change on the other
  always @(spi.sck) begin
    if (spi.cs_n === 1'b0) begin
      if (spi.sck == edge_sel) begin
        rx_byte = lsb_first ? {spi.mosi, rx_byte[7:1]} : {rx_byte[6:0], spi.mosi};
        rx_bits++;
        if (rx_bits % 8 == 0 && rx_bits <= (wide ? 32 : 24)) rx_hdr = {rx_hdr[23:0], rx_byte};
      end else begin
        miso = tx_bit(n_tx);
        n_tx++;
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Bench for the boot loader: registers, host path, FIFO, EEPROM loads.
// Assumes the EEPROM model on the serial pins; runs about 40k cycles.
module tb_top
  import sebl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock = 1'b0;
  logic          rst;
  sebl_reg_req_t reg_req;
  logic [7:0]    reg_rdata, supply_sample, host_coef_data, coef_data, gain_atten_tenths;
  sebl_spi_t     spi;
  logic          spi_miso, host_coef_valid, host_coef_ready, coef_valid, coef_ready;
  logic [4:0]    analog_gain_code;
  logic          marker, load_busy;
  logic          m_edge, m_lsb, m_wide, m_bad; // Format handed to the EEPROM model
  logic [31:0]   m_hdr;
  int            m_bits;
  int            n_fail = 0;
  int            samples_checked = 0;

  always #2.5 clock = ~clock;

  sebl_loader sebl_loader_inst (.clock(clock), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .supply_sample(supply_sample), .spi(spi), .spi_miso(spi_miso),
    .host_coef_valid(host_coef_valid), .host_coef_data(host_coef_data),
    .host_coef_ready(host_coef_ready), .coef_valid(coef_valid), .coef_ready(coef_ready),
    .coef_data(coef_data), .analog_gain_code(analog_gain_code),
    .gain_atten_tenths(gain_atten_tenths), .biquad_first_coef_marker(marker),
    .load_busy(load_busy));
  sebl_eeprom_model sebl_eeprom_model_inst (.spi(spi), .miso(spi_miso), .edge_sel(m_edge),
    .lsb_first(m_lsb), .wide(m_wide), .bad_crc(m_bad), .rx_hdr(m_hdr), .rx_bits(m_bits));

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One-cycle strobes; reads look one cycle after the strobe edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req <= '0;
    #1 check(e, reg_rdata);
  endtask
  task automatic do_reset();
    @(posedge clock) rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
  endtask
  function automatic logic [7:0] rw_val(logic [7:0] a);
    return (a == 8'h56) ? 8'hEA : {a[3:0], 4'h5}; // Keeps the source bit clear
  endfunction

  // Takes n words off the DSP stream; EEPROM words come from the model image
  task automatic drain(input int n, input logic eep);
    int k;
    k = 0;
    coef_ready <= 1'b1;
    for (int i = 0; i < 40000 && k < n; i++) begin
      @(negedge clock);
      if (coef_valid === 1'b1) begin
        check(eep ? sebl_eeprom_model_inst.img[k] : k[7:0], coef_data);
        k++;
      end
      @(posedge clock);
    end
    coef_ready <= 1'b0;
    check(n, k);
  endtask

  // Every offset after reset, unmapped neighbours included
  task automatic t_reset_values();
    for (logic [7:0] a = 8'h53; a <= 8'h5F; a++) begin
      rd_chk(a, (a == 8'h57) ? 8'h03 : (a == 8'h5E) ? 8'hC6 : 8'h00);
    end
  endtask

  // Write all, read back; status and supply refuse writes
  task automatic t_reg_rw();
    for (logic [7:0] a = 8'h54; a <= 8'h5E; a++) wr(a, rw_val(a));
    for (logic [7:0] a = 8'h54; a <= 8'h5E; a++) begin
      rd_chk(a, (a == 8'h5B || a == 8'h5D) ? 8'h00 : (a == 8'h5E) ? 8'hC6 : rw_val(a));
    end
    check(5'h05, analog_gain_code);
    check(8'd25, gain_atten_tenths);
    check(1'b1, marker);
    wr(8'h54, 8'h1F);
    repeat (2) @(negedge clock);
    check(8'd155, gain_atten_tenths);
  endtask

  // Each rate code: length of the first sck high phase, then abort by reset
  task automatic t_rates();
    int h;
    for (int r = 0; r < 4; r++) begin
      wr(8'h55, r[7:0]);
      wr(8'h56, 8'h01);
      for (int i = 0; i < 400 && spi.sck !== 1'b1; i++) @(negedge clock);
      h = 0;
      for (int i = 0; i < 400 && spi.sck === 1'b1; i++) begin
        h++;
        @(negedge clock);
      end
      check(80 >> r, h);
      do_reset();
    end
  endtask

  // Host stream fills the FIFO until it refuses, then drains in order
  task automatic t_host_fifo();
    int  n;
    logic ok;
    n = 0;
    host_coef_valid <= 1'b1;
    host_coef_data <= 8'h00;
    for (int i = 0; i < 40; i++) begin
      @(negedge clock) ok = host_coef_ready;
      @(posedge clock);
      if (ok) begin
        n++;
        host_coef_data <= n[7:0];
      end
    end
    host_coef_valid <= 1'b0;
    check(32, n);
    drain(32, 1'b0);
  endtask

  // Full load with the DSP stalled long enough that only backpressure keeps it busy
  task automatic t_load(input logic [7:0] cfg, input logic [7:0] op, input logic [23:0] ad,
                        input logic bad);
    m_edge <= cfg[2];
    m_lsb <= cfg[1];
    m_wide <= cfg[5];
    m_bad <= bad;
    wr(8'h55, 8'h03);
    wr(8'h57, op);
    wr(8'h58, ad[23:16]);
    wr(8'h59, ad[15:8]);
    wr(8'h5A, ad[7:0]);
    wr(8'h56, cfg & 8'hFE);
    wr(8'h56, cfg);
    rd_chk(8'h5B, 8'h00);
    check(1'b0, spi.cs_n);
    check(1'b0, host_coef_ready);
    repeat (12000) @(negedge clock);
    check({1'b1, 1'b1, 1'b0}, {load_busy, coef_valid, spi.sck});
    wr(8'h56, cfg);
    drain(64, 1'b1);
    for (int i = 0; i < 2000 && load_busy !== 1'b0; i++) @(negedge clock);
    rd_chk(8'h5B, {6'h00, bad, 1'b1});
    check(1'b1, spi.cs_n);
    check(cfg[5] ? {op, ad} : {8'h00, op, ad[15:0]}, m_hdr);
    check((cfg[5] ? 68 : 67) * 8, m_bits);
  endtask

  initial begin
    rst = 1'b1;
    reg_req = '0;
    supply_sample = 8'hC6;
    host_coef_valid = 1'b0;
    host_coef_data = 8'h00;
    coef_ready = 1'b0;
    {m_edge, m_lsb, m_wide, m_bad} = 4'h0;
    do_reset();
    t_reset_values();
    t_reg_rw();
    do_reset();
    t_rates();
    t_host_fifo();
    t_load(8'h01, 8'h03, 24'hAB1234, 1'b0);
    t_load(8'h27, 8'h6B, 24'h56789A, 1'b1);
    complete_run();
  end

  // Tests need about 40k cycles; twice that means a hang
  initial begin
    #400000;
    n_fail++;
    complete_run();
  end
endmodule

bind sebl_loader sebl_loader_properties sebl_loader_properties_inst (.clock(clock), .rst(rst),
  .reg_req(reg_req), .analog_gain_code(analog_gain_code), .gain_atten_tenths(gain_atten_tenths),
  .biquad_first_coef_marker(biquad_first_coef_marker), .load_busy(load_busy), .spi(spi),
  .host_coef_ready(host_coef_ready), .coef_valid(coef_valid), .coef_ready(coef_ready),
  .coef_data(coef_data));
